// File: exec_pkg.sv
// Shared constants and types of the integer execution block.
// Assumes a single core clock; all users import the whole package.
package exec_pkg;

  // Instruction group handled by the block
  typedef enum logic [3:0] {
    OP_RD_PSR, OP_RD_TBR, OP_RD_WIM, OP_RD_ASR, OP_RD_Y,
    OP_RESTORE, OP_SAVE, OP_RETT, OP_SCAN, OP_SETHI,
    OP_SLL, OP_SMUL, OP_SMULCC
  } op_t;

  // Trap type codes (arbitrary values)
  localparam logic [7:0] TT_ILLEGAL = 8'h01;
  localparam logic [7:0] TT_PRIV = 8'h02;
  localparam logic [7:0] TT_WIN_OVF = 8'h03;
  localparam logic [7:0] TT_WIN_UNF = 8'h04;
  localparam logic [7:0] TT_MISALIGN = 8'h05;

  // Ancillary selector that is implemented
  localparam logic [4:0] ASR_SELECT = 5'd17;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_PSR = 8'h00;
  localparam logic [7:0] OFS_TBR = 8'h04;
  localparam logic [7:0] OFS_WIM = 8'h08;
  localparam logic [7:0] OFS_Y = 8'h0C;
  localparam logic [7:0] OFS_ASR = 8'h10;

  // Field positions
  localparam int PSR_CWP_LSB = 0;
  localparam int PSR_ET_BIT = 5;
  localparam int PSR_PS_BIT = 6;
  localparam int PSR_S_BIT = 7;
  localparam int PSR_ICC_LSB = 20;
  localparam int TBR_TT_LSB = 4;
  localparam int TBR_BASE_LSB = 12;

  // Reset values
  localparam logic RST_SUPERVISOR = 1'b1;
  localparam logic RST_TRAP_ENABLE = 1'b0;
  localparam logic [2:0] RST_CWP = 3'h0;
  localparam logic [7:0] RST_WIM = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Multiply latencies in core clock cycles
  localparam logic [2:0] MUL_WORD_CYCLES = 3'd5;
  localparam logic [2:0] MUL_HALF_CYCLES = 3'd3;
  localparam logic [2:0] MUL_BYTE_CYCLES = 3'd2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: mul_if.sv
// Carrier between the execution control and the multiplier.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface mul_if;
  logic start;
  logic [31:0] multiplicand;
  logic [31:0] multiplier;
  logic busy;
  logic done;
  logic [31:0] productLo;
  logic [31:0] productHi;

  modport ctrl (output start, multiplicand, multiplier,
                input busy, done, productLo, productHi);
  modport unit (input start, multiplicand, multiplier,
                output busy, done, productLo, productHi);
endinterface

// File: mul_unit.sv
// Signed 32x32 multiplier with operand-dependent latency.
// Assumes start is only raised while busy is low.
`timescale 1ns/10ps
module mul_unit
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control side
  mul_if.unit m
);

  logic [63:0] product;
  logic [2:0] count;
  logic [2:0] next_cycles;

  // Latency picked from how many upper bits of the operand copy its sign
  always_comb begin
    next_cycles = MUL_WORD_CYCLES;
    if (&m.multiplier[31:7] || ~|m.multiplier[31:7]) begin
      next_cycles = MUL_BYTE_CYCLES;
    end else if (&m.multiplier[31:15] || ~|m.multiplier[31:15]) begin
      next_cycles = MUL_HALF_CYCLES;
    end
  end

  // Product held in a register so results come out of flip-flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      product <= 64'h0000_0000_0000_0000;
    end else if (m.start) begin
      product <= $signed(m.multiplicand) * $signed(m.multiplier);
    end
  end

  // Countdown; done is seen one cycle before the control registers it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      m.busy <= 1'b0;
      count <= 3'd0;
    end else if (m.start) begin
      m.busy <= 1'b1;
      count <= next_cycles - 3'd1;
    end else if (m.busy) begin
      if (count == 3'd1) begin
        m.busy <= 1'b0;
      end
      count <= count - 3'd1;
    end
  end

  assign m.done = m.busy && (count == 3'd1);
  assign m.productLo = product[31:0];
  assign m.productHi = product[63:32];

endmodule

// File: integer_exec_unit.sv
// Integer execution block: state reads, windows, trap return, scan,
// upper-immediate load, left shift and signed multiply.
// Assumes one instruction is offered at a time on the issue port and
// that the pipeline around it handles fetch and trap vectoring.
`timescale 1ns/10ps
module integer_exec_unit
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Issue port
  input wire logic issueValid,
  output logic issueReady,
  input wire op_t issueOp,
  input wire logic [31:0] sourceOne,
  input wire logic [31:0] sourceTwo,
  input wire logic [12:0] signedShortImmediate,
  input wire logic useImmediate,
  input wire logic [4:0] sourceOneField,
  input wire logic [4:0] destField,
  input wire logic [21:0] upperImmediate,
  // Completion port
  output logic doneValid,
  output logic resultWrite,
  output logic [31:0] resultData,
  output logic trapValid,
  output logic [7:0] trapCode,
  output logic jumpValid,
  output logic [31:0] jumpTarget,
  output logic errorMode,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Architectural state
  logic [2:0] current_window_pointer;
  logic etBit, psBit, supBit;
  logic [3:0] icc;
  logic [19:0] trapBase;
  logic [7:0] trapTypeField;
  logic [7:0] wim;
  logic [31:0] yReg, asrReg;
  logic ccPending;
  // Bus holding state
  logic awHeld, wHeld;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  // Decode results
  logic issueFire, isMul, wrFire;
  logic [31:0] opTwo, sum, scanVal, psrWord, tbrWord;
  logic [31:0] psrMerge, tbrMerge, wimMerge;
  logic [2:0] upCwp, downCwp;
  logic next_write, next_trap, next_winCommit, next_rett, next_error;
  logic [31:0] next_result;
  logic [7:0] next_code;
  logic [2:0] next_cwp;

  mul_if mulBus ();

  mul_unit u_mul_unit (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .m(mulBus)
  );

  // Byte-lane merge of a bus write into a register word
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Position of the first set bit seen from the MSB, 63 when empty
  function automatic logic [5:0] firstSetFromMsb(input logic [31:0] v);
    logic [5:0] pos;
    pos = 6'd63;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        pos = 6'(31 - i);
      end
    end
    return pos;
  endfunction

  assign psrWord = (32'(icc) << PSR_ICC_LSB) | (32'(supBit) << PSR_S_BIT)
      | (32'(psBit) << PSR_PS_BIT) | (32'(etBit) << PSR_ET_BIT)
      | (32'(current_window_pointer) << PSR_CWP_LSB);
  assign tbrWord = (32'(trapBase) << TBR_BASE_LSB)
      | (32'(trapTypeField) << TBR_TT_LSB);

  // Bus write data merged per lane; named so fields can be sliced out
  assign psrMerge = laneMerge(psrWord, wrData, wrStrb);
  assign tbrMerge = laneMerge(tbrWord, wrData, wrStrb);
  assign wimMerge = laneMerge({24'h00_0000, wim}, wrData, wrStrb);

  // Error mode halts issue; a running multiply also holds it off
  assign issueReady = !mulBus.busy && !errorMode;
  assign issueFire = issueValid && issueReady;
  assign isMul = (issueOp == OP_SMUL) || (issueOp == OP_SMULCC);
  assign mulBus.start = issueFire && isMul;
  assign mulBus.multiplicand = sourceOne;
  assign mulBus.multiplier = opTwo;

  // Operand shaping shared by the window ops, trap return and shifts
  always_comb begin
    opTwo = useImmediate ? {{19{signedShortImmediate[12]}},
        signedShortImmediate} : sourceTwo;
    sum = sourceOne + opTwo;
    upCwp = current_window_pointer + 3'd1;
    downCwp = current_window_pointer - 3'd1;
    scanVal = sourceOne ^ 32'($signed(opTwo) >>> 1);
  end

  // Single-cycle instruction decode and trap priority
  always_comb begin
    next_write = 1'b0;
    next_trap = 1'b0;
    next_winCommit = 1'b0;
    next_rett = 1'b0;
    next_error = 1'b0;
    next_result = 32'h0000_0000;
    next_code = TT_ILLEGAL;
    next_cwp = current_window_pointer;
    case (issueOp)
      OP_RD_PSR, OP_RD_TBR, OP_RD_WIM, OP_RD_ASR: begin
        if (!supBit) begin
          next_trap = 1'b1;
          next_code = TT_PRIV;
        end else if (issueOp == OP_RD_ASR
            && sourceOneField != ASR_SELECT) begin
          next_trap = 1'b1;
          next_code = TT_ILLEGAL;
        end else begin
          next_write = 1'b1;
          next_result = (issueOp == OP_RD_PSR) ? psrWord
              : (issueOp == OP_RD_TBR) ? tbrWord
              : (issueOp == OP_RD_WIM) ? {24'h00_0000, wim} : asrReg;
        end
      end
      OP_RD_Y: begin
        next_write = 1'b1;
        next_result = yReg;
      end
      OP_RESTORE, OP_SAVE: begin
        next_cwp = (issueOp == OP_RESTORE) ? upCwp : downCwp;
        if (wim[next_cwp]) begin
          next_trap = 1'b1;
          next_code = (issueOp == OP_RESTORE) ? TT_WIN_UNF : TT_WIN_OVF;
        end else begin
          next_winCommit = 1'b1;
          next_write = 1'b1;
          next_result = sum;
        end
      end
      OP_RETT: begin
        next_cwp = upCwp;
        if (etBit) begin
          next_trap = 1'b1;
          next_code = supBit ? TT_ILLEGAL : TT_PRIV;
        end else if (!supBit) begin
          next_error = 1'b1;
          next_code = TT_PRIV;
        end else if (wim[upCwp]) begin
          next_error = 1'b1;
          next_code = TT_WIN_UNF;
        end else if (sum[1:0] != 2'b00) begin
          next_error = 1'b1;
          next_code = TT_MISALIGN;
        end else begin
          next_rett = 1'b1;
        end
      end
      OP_SCAN: begin
        next_write = 1'b1;
        next_result = {26'h000_0000, firstSetFromMsb(scanVal)};
      end
      OP_SETHI: begin
        next_write = (destField != 5'd0)
            || (upperImmediate != 22'd0);
        next_result = {upperImmediate, 10'h000};
      end
      OP_SLL: begin
        next_write = 1'b1;
        next_result = sourceOne << opTwo[4:0];
      end
      default: begin
        next_write = 1'b0;
      end
    endcase
  end

  // Completion outputs, registered; multiply results land here too
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      doneValid <= 1'b0;
      resultWrite <= 1'b0;
      resultData <= RST_WORD;
      trapValid <= 1'b0;
      trapCode <= 8'h00;
      jumpValid <= 1'b0;
      jumpTarget <= RST_WORD;
    end else if (mulBus.done) begin
      doneValid <= 1'b1;
      resultWrite <= 1'b1;
      resultData <= mulBus.productLo;
      trapValid <= 1'b0;
      jumpValid <= 1'b0;
    end else begin
      doneValid <= issueFire && !isMul;
      resultWrite <= issueFire && !isMul && next_write;
      trapValid <= issueFire && !isMul && next_trap;
      jumpValid <= issueFire && next_rett;
      if (issueFire && !isMul) begin
        resultData <= next_result;
        trapCode <= next_code;
        jumpTarget <= sum;
      end
    end
  end

  // Processor state; instruction effects win over a bus write
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      current_window_pointer <= RST_CWP;
      etBit <= RST_TRAP_ENABLE;
      psBit <= RST_SUPERVISOR;
      supBit <= RST_SUPERVISOR;
      icc <= 4'h0;
    end else begin
      if (wrFire && wrAddr == OFS_PSR) begin
        {icc, supBit, psBit, etBit, current_window_pointer} <= {psrMerge[PSR_ICC_LSB +: 4],
            psrMerge[PSR_S_BIT -: 3], psrMerge[PSR_CWP_LSB +: 3]};
      end
      if (issueFire && (next_winCommit || next_rett)) begin
        current_window_pointer <= next_cwp;
      end
      if (issueFire && next_rett) begin
        supBit <= psBit;
        etBit <= 1'b1;
      end
      if (mulBus.done && ccPending) begin
        icc <= {mulBus.productLo[31], mulBus.productLo == 32'd0,
            2'b00};
      end
    end
  end

  // Trap base, window mask, multiply-high and ancillary registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trapBase <= 20'h0_0000;
      trapTypeField <= 8'h00;
      wim <= RST_WIM;
      yReg <= RST_WORD;
      asrReg <= RST_WORD;
      ccPending <= 1'b0;
      errorMode <= 1'b0;
    end else begin
      if (wrFire && wrAddr == OFS_TBR) begin
        {trapBase, trapTypeField} <= tbrMerge[31:TBR_TT_LSB];
      end
      if (wrFire && wrAddr == OFS_WIM) begin
        wim <= wimMerge[7:0];
      end
      if (wrFire && wrAddr == OFS_Y) begin
        yReg <= laneMerge(yReg, wrData, wrStrb);
      end
      if (wrFire && wrAddr == OFS_ASR) begin
        asrReg <= laneMerge(asrReg, wrData, wrStrb);
      end
      if (issueFire && next_error) begin
        trapTypeField <= next_code;
        errorMode <= 1'b1;
      end
      if (mulBus.start) begin
        ccPending <= (issueOp == OP_SMULCC);
      end
      if (mulBus.done) begin
        yReg <= mulBus.productHi;
      end
    end
  end

  // Bus write side: address and data taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= RST_WORD;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrAddr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrAddr > OFS_ASR) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Bus read side: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_PSR: s_axi_rdata <= psrWord;
        OFS_TBR: s_axi_rdata <= tbrWord;
        OFS_WIM: s_axi_rdata <= {24'h00_0000, wim};
        OFS_Y: s_axi_rdata <= yReg;
        OFS_ASR: s_axi_rdata <= asrReg;
        default: begin
          s_axi_rdata <= RST_WORD;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the issue and completion behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_priv_read: assert property (
      issueFire && !supBit && (issueOp == OP_RD_PSR
      || issueOp == OP_RD_TBR || issueOp == OP_RD_WIM
      || issueOp == OP_RD_ASR) |=> trapValid && trapCode == TT_PRIV
      && !resultWrite) else $error("state read not trapped");
  chk_asr_select: assert property (
      issueFire && supBit && issueOp == OP_RD_ASR
      && sourceOneField != ASR_SELECT |=> trapValid
      && trapCode == TT_ILLEGAL) else $error("bad selector accepted");
  chk_y_read: assert property (
      issueFire && issueOp == OP_RD_Y |=> resultWrite && !trapValid
      && resultData == $past(yReg))
      else $error("multiply-high read wrong");
  chk_restore_window: assert property (
      issueFire && issueOp == OP_RESTORE
      |=> (current_window_pointer == $past(upCwp)) != trapValid)
      else $error("restore pointer wrong");
  chk_save_window: assert property (
      issueFire && issueOp == OP_SAVE && wim[downCwp]
      |=> trapValid && trapCode == TT_WIN_OVF && $stable(current_window_pointer))
      else $error("save overflow missed");
  chk_window_sum: assert property (
      issueFire && issueOp == OP_SAVE && !wim[downCwp]
      |=> resultWrite && resultData == $past(sum))
      else $error("save sum wrong");
  chk_rett_return: assert property (
      issueFire && issueOp == OP_RETT && !etBit && supBit
      && !wim[upCwp] && sum[1:0] == 2'b00
      |=> etBit && supBit == $past(psBit) && jumpValid)
      else $error("trap return wrong");
  chk_rett_user: assert property (
      issueFire && issueOp == OP_RETT && etBit && !supBit
      |=> trapValid && trapCode == TT_PRIV)
      else $error("trap return user case");
  chk_rett_error: assert property (
      issueFire && issueOp == OP_RETT && !etBit && !supBit
      |=> errorMode && trapTypeField == TT_PRIV && !trapValid)
      else $error("error mode not entered");
  chk_rett_align: assert property (
      issueFire && issueOp == OP_RETT && !etBit && supBit
      && !wim[upCwp] && sum[1:0] != 2'b00
      |=> trapTypeField == TT_MISALIGN) else $error("misalign code");
  chk_scan_empty: assert property (
      issueFire && issueOp == OP_SCAN && scanVal == 32'd0
      |=> resultData == 32'd63) else $error("scan empty result");
  chk_sethi_nop: assert property (
      issueFire && issueOp == OP_SETHI && destField == 5'd0
      && upperImmediate == 22'd0 |=> doneValid && !resultWrite)
      else $error("nop wrote");
  chk_mul_byte: assert property (
      mulBus.start && opTwo[31:7] == 25'd0
      |=> !doneValid ##1 doneValid) else $error("byte latency");
  chk_mul_word: assert property (
      mulBus.start && !(&opTwo[31:15]) && |opTwo[31:15]
      |=> !doneValid [*4] ##1 doneValid) else $error("word latency");
  chk_mul_codes: assert property (
      doneValid && $past(mulBus.done) && $past(ccPending)
      |-> icc == {resultData[31], resultData == 32'd0, 2'b00})
      else $error("multiply codes wrong");

  cov_mul_cc: cover property (mulBus.start && issueOp == OP_SMULCC);
  cov_rett_ok: cover property (issueFire && next_rett);
  cov_restore_trap: cover property (issueFire && issueOp == OP_RESTORE
      && next_trap);
  cov_error_mode: cover property ($rose(errorMode));

endmodule

// File: integer_exec_unit_tb.sv
// Self-checking bench of the integer execution block.
// Assumes exec_pkg and the design files are compiled before it.
`timescale 1ns/10ps
module integer_exec_unit_tb
  import exec_pkg::*;
;
  logic core_clk = 0, rst_b = 0, issueValid = 0, useImmediate = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, trapCode;
  logic [31:0] sourceOne = '0, sourceTwo = '0, s_axi_wdata = '0;
  logic [12:0] signedShortImmediate = '0;
  logic [4:0] sourceOneField = '0, destField = '0;
  logic [21:0] upperImmediate = '0;
  op_t issueOp = OP_SLL;
  logic issueReady, doneValid, resultWrite, trapValid, jumpValid;
  logic errorMode, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, wrSeen, trSeen, jpSeen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp, wresp;
  logic [31:0] resultData, jumpTarget, s_axi_rdata, readWord;
  logic signed [63:0] prod;
  logic [31:0] mulB [5] = '{32'h0000_007F, 32'hFFFF_FF80,
    32'h0000_0080, 32'hFFFF_8000, 32'h0001_0000};
  int mulLat [5] = '{MUL_BYTE_CYCLES, MUL_BYTE_CYCLES, MUL_HALF_CYCLES,
    MUL_HALF_CYCLES, MUL_WORD_CYCLES};
  int errCount = 0, samplesChecked = 0, lat;

  integer_exec_unit u_integer_exec_unit (
    .core_clk, .rst_b, .issueValid, .issueReady, .issueOp, .sourceOne,
    .sourceTwo, .signedShortImmediate, .useImmediate, .sourceOneField,
    .destField, .upperImmediate, .doneValid, .resultWrite, .resultData,
    .trapValid, .trapCode, .jumpValid, .jumpTarget, .errorMode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // 100 ns core clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // Verdict, reached from the main sequence or a wait that runs out
  task automatic testDone();
    $display("Checks %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      errCount++;
      $display("[FAIL] handshake expected 1 seen 0");
      testDone();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Extra edge after release: the release edge itself takes no request
  task automatic rst();
    rst_b <= 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1;
    @(posedge core_clk);
  endtask

  // Bus write; each channel dropped only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      bh = s_axi_bvalid;
      wresp = s_axi_bresp;
      @(posedge core_clk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      if (bh) break;
    end
    s_axi_bready <= 0;
    hang(n);
    // Spare edge so a following call never lowers and raises bready at once
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ah = s_axi_arready;
      rh = s_axi_rvalid;
      readWord = s_axi_rdata;
      rresp = s_axi_rresp;
      @(posedge core_clk);
      if (ah) s_axi_arvalid <= 0;
      if (rh) break;
    end
    s_axi_rready <= 0;
    hang(n);
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    rd(a);
    chk(nm, e, readWord);
  endtask

  // Issue one instruction; lat counts cycles from take to completion
  task automatic ex(input op_t op, input logic [31:0] a, b);
    int n;
    issueOp <= op;
    sourceOne <= a;
    sourceTwo <= b;
    issueValid <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      if (issueReady === 1'b1) break;
    end
    hang(n);
    @(posedge core_clk);
    issueValid <= 0;
    for (lat = 1; lat < 40; lat++) begin
      @(negedge core_clk);
      if (doneValid === 1'b1) break;
    end
    hang(lat);
    wrSeen = resultWrite;
    trSeen = trapValid;
    jpSeen = jumpValid;
    @(posedge core_clk);
  endtask

  task automatic run(input op_t op, input logic [31:0] a, b, res,
                     input logic w, input logic [7:0] tc);
    ex(op, a, b);
    chk("write", {31'h0, w}, {31'h0, wrSeen});
    chk("trap", {31'h0, tc != 0}, {31'h0, trSeen});
    if (w) chk("result", res, resultData);
    if (tc != 0) chk("code", {24'h0, tc}, {24'h0, trapCode});
  endtask

  // Error mode refuses issue and leaves its code in the trap base
  task automatic stuck(input logic [7:0] tc);
    chk("error", 1, {31'h0, errorMode});
    chk("jump", 0, {31'h0, jpSeen});
    chk("ready", 0, {31'h0, issueReady});
    rd(OFS_TBR);
    chk("tt", {24'h0, tc}, {24'h0, readWord[11:4]});
    rst();
  endtask

  // Main sequence
  initial begin
    rst();
    rdc(OFS_PSR, 32'h0000_00C0, "psr");
    rd(8'h14);
    chk("resp", {30'h0, RESP_SLVERR}, {30'h0, rresp});
    wr(8'h14, '1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
    wr(OFS_ASR, 32'h1234_5678);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, wresp});
    run(OP_RD_PSR, '0, '0, 32'h0000_00C0, 1, 0);
    sourceOneField <= 5'd17;
    run(OP_RD_ASR, '0, '0, 32'h1234_5678, 1, 0);
    sourceOneField <= 5'd16;
    run(OP_RD_ASR, '0, '0, '0, 0, TT_ILLEGAL);
    destField <= 5'd3;
    upperImmediate <= 22'h2A_AAAA;
    run(OP_SETHI, '0, '0, 32'hAAAA_A800, 1, 0);
    destField <= 5'd0;
    upperImmediate <= 22'h0;
    run(OP_SETHI, '0, '0, '0, 0, 0);
    run(OP_SLL, 32'h8000_0001, 32'hFFFF_FFE1, 32'h2, 1, 0);
    useImmediate <= 1;
    signedShortImmediate <= 13'h1FE4;
    run(OP_SLL, 32'h8000_0001, '0, 32'h10, 1, 0);
    useImmediate <= 0;
    run(OP_SCAN, 32'h0000_0001, '0, 32'd31, 1, 0);
    run(OP_SCAN, '1, 32'h8000_0000, 32'd2, 1, 0);
    run(OP_SCAN, '0, '0, 32'd63, 1, 0);
    // Window moves wrap modulo 8 against the invalid mask
    wr(OFS_WIM, 32'h0000_0080);
    run(OP_SAVE, 32'd5, 32'd7, '0, 0, TT_WIN_OVF);
    rdc(OFS_PSR, 32'h0000_00C0, "cwp kept");
    wr(OFS_WIM, 32'h0000_0001);
    run(OP_SAVE, 32'd5, 32'd7, 32'd12, 1, 0);
    rdc(OFS_PSR, 32'h0000_00C7, "cwp down");
    run(OP_RESTORE, 32'd5, 32'd7, '0, 0, TT_WIN_UNF);
    wr(OFS_WIM, 32'h0000_0080);
    run(OP_RESTORE, '1, 32'd2, 32'd1, 1, 0);
    rdc(OFS_PSR, 32'h0000_00C0, "cwp up");
    // Byte, halfword and word ranges of the second operand
    for (int i = 0; i < 5; i++) begin
      ex(OP_SMUL, 32'h8000_0003, mulB[i]);
      prod = $signed(32'h8000_0003) * $signed(mulB[i]);
      chk("low", prod[31:0], resultData);
      chk("latency", mulLat[i], lat);
      rdc(OFS_Y, prod[63:32], "high");
    end
    wr(OFS_PSR, 32'h0030_00C0);
    run(OP_SMULCC, '1, 32'd1, '1, 1, 0);
    rdc(OFS_PSR, 32'h0080_00C0, "icc neg");
    run(OP_SMULCC, 32'h0001_0000, 32'h0001_0000, '0, 1, 0);
    rdc(OFS_PSR, 32'h0040_00C0, "icc zero");
    // Only the strobed byte lane of a write lands
    s_axi_wstrb <= 4'h2;
    wr(OFS_ASR, 32'hAABB_CCDD);
    s_axi_wstrb <= 4'hF;
    rdc(OFS_ASR, 32'h1234_CC78, "strobe");
    // User mode: state reads trap, the high word stays readable
    wr(OFS_WIM, 32'h0000_0002);
    wr(OFS_PSR, 32'h0000_0040);
    sourceOneField <= 5'd17;
    for (int i = 0; i < 4; i++) begin
      run(op_t'(i), '0, '0, '0, 0, TT_PRIV);
    end
    run(OP_RD_Y, '0, '0, 32'd1, 1, 0);
    // Each trap return below stands where a jump-and-link has just run
    // in the surrounding pipeline, so no other op sits before it
    run(OP_RETT, 32'h100, 32'd2, '0, 0, 0);
    stuck(TT_PRIV);
    wr(OFS_WIM, 32'h0000_0002);
    run(OP_RETT, 32'h100, 32'd2, '0, 0, 0);
    stuck(TT_WIN_UNF);
    run(OP_RETT, 32'h100, 32'd1, '0, 0, 0);
    stuck(TT_MISALIGN);
    // Good return wraps the pointer from 7 to 0
    wr(OFS_PSR, 32'h0000_0087);
    useImmediate <= 1;
    signedShortImmediate <= 13'h1FFC;
    run(OP_RETT, 32'h108, 32'hFFFF, '0, 0, 0);
    chk("jump", 1, {31'h0, jpSeen});
    chk("target", 32'h104, jumpTarget);
    rdc(OFS_PSR, 32'h0000_0020, "psr rett");
    run(OP_RETT, 32'h108, '0, '0, 0, TT_PRIV);
    wr(OFS_PSR, 32'h0000_00A0);
    run(OP_RETT, 32'h108, '0, '0, 0, TT_ILLEGAL);
    chk("no error", 0, {31'h0, errorMode});
    testDone();
  end
endmodule
